// [src/mbps_pkg.sv]
// constants and types for the memory bus pin function select block
package mbps_pkg;

  // register map
  localparam logic [31:0] SEL_ADDR      = 32'hE002_C014;
  localparam logic [31:0] SEL_WR_MASK   = 32'h0FF3_E9FC;
  localparam logic [31:0] SEL_RST_VAL   = 32'h0060_00C0;

  // field positions
  localparam int DBG_BIT    = 2;
  localparam int TRC_BIT    = 3;
  localparam int WIDTH_LSB  = 4;
  localparam int ANALOG_IN_SIX_BIT   = 6;
  localparam int ANALOG_IN_SEVEN_BIT   = 7;
  localparam int WE_BIT     = 8;
  localparam int CS1_BIT    = 11;
  localparam int CLOCK_OUTPUT_PIN_BIT   = 13;
  localparam int CS2_LSB    = 14;
  localparam int CS3_LSB    = 16;
  localparam int D2928_BIT  = 20;
  localparam int ANALOG_IN_FOUR_BIT   = 21;
  localparam int ANALOG_IN_FIVE_BIT   = 22;
  localparam int A0_BIT     = 23;
  localparam int A1_BIT     = 24;
  localparam int ADDR_LSB   = 25;
  localparam int ADDR_W     = 3;

  // field encodings
  localparam logic [1:0] CS_SEL_CODE   = 2'h1;
  localparam logic [2:0] ADDR_NONE     = 3'h0;
  localparam logic [2:0] ADDR_ALL      = 3'h7;
  localparam logic [1:0] STRAP_BUS8    = 2'h0;
  localparam logic [1:0] STRAP_NOBUS   = 2'h3;

  // pin counts
  localparam int P1_W       = 37;
  localparam int P23_W      = 32;
  localparam int AMASK_W    = 22;

  typedef enum logic [1:0] {
    WIDTH_8    = 2'h0,
    WIDTH_16   = 2'h1,
    WIDTH_32   = 2'h2,
    WIDTH_NONE = 2'h3
  } mbps_width_e;

  typedef enum logic [0:0] {
    ST_STRAP,
    ST_RUN
  } mbps_state_e;

endpackage : mbps_pkg

// [src/mbps_cfg_if.sv]
// address field to address line mask carrier
`timescale 1ns/100ps
`default_nettype none
interface mbps_cfg_if;
  logic [2:0]  addr_field;
  logic [21:0] addr_mask;

  modport decoder (input addr_field, output addr_mask);
  modport user    (output addr_field, input addr_mask);
endinterface : mbps_cfg_if
`default_nettype wire

// [src/mbps_addr_map.sv]
// decodes the upper address line field into a mask of pins 23..2
`timescale 1ns/100ps
`default_nettype none
module mbps_addr_map (
  // config
  mbps_cfg_if.decoder cfg
);

  // highest enabled address line for a field code, zero when none
  function automatic logic [4:0] top_line(input logic [2:0] code);
    case (code)
      3'h1:    top_line = 5'h03;
      3'h2:    top_line = 5'h05;
      3'h3:    top_line = 5'h07;
      3'h4:    top_line = 5'h0B;
      3'h5:    top_line = 5'h0F;
      3'h6:    top_line = 5'h13;
      3'h7:    top_line = 5'h17;
      default: top_line = 5'h00;
    endcase
  endfunction

  wire logic [4:0] top;
  assign top = top_line(cfg.addr_field);

  always_comb begin
    for (int i = 0; i < 22; i++) begin
      cfg.addr_mask[i] = (cfg.addr_field != mbps_pkg::ADDR_NONE) && (5'(i + 2) <= top);
    end
  end

endmodule : mbps_addr_map
`default_nettype wire

// [src/mbps_pin_select.sv]
// memory bus pin function select register with apb slave and pin decode
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - bit 2 gives debug pin group to debug port, else general-purpose.
// - bit 3 gives trace pin group to trace port, else general-purpose.
// - bus-width field loads from boot strap pins at reset.
// - width 11 frees low data byte, chip select 0, output strobe, lane 0.
// - width 01 or 10 maps data 15..8 and byte lane one to bus.
// - outside width 10, bits 6 and 7 pick analogue inputs six, seven.
// - bit 8 picks write strobe over port pin 3.27, resets 0.
// - bit 11 picks chip select one over port pin 3.26, resets 0.
// - unless address field is 111, bit 13 picks clock output, resets 0.
// - field 15:14 at 01 picks chip select two, resets 00.
// - field 17:16 at 01 picks chip select three, resets 00.
// - outside width 10, bit 20 keeps pins 2.29/2.28 as port pins.
// - outside width 10, bit 21 picks analogue input four, resets 1.
// - outside width 10, bit 22 picks analogue input five, resets 1.
// - bit 23 enables address line 0; resets 1 only for straps 00.
// - bit 24 enables address line 1.
// - field 27:25 sets top address line; resets 000 for straps 11.
// - direction register only steers pins left at general-purpose use.
module mbps_pin_select (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // boot straps
  input  wire logic [1:0]  boot_strap_pins,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // direction from general-purpose port and from the owning functions
  input  wire logic [36:0] port1_dir,
  input  wire logic [31:0] port2_dir,
  input  wire logic [31:0] port3_dir,
  input  wire logic [36:0] port1_fn_oe,
  input  wire logic [31:0] port2_fn_oe,
  input  wire logic [31:0] port3_fn_oe,
  // per pin function select, 1 = alternate function
  output logic [36:0]      port1_fn_sel,
  output logic [31:0]      port2_fn_sel,
  output logic [31:0]      port3_fn_sel,
  // effective pin output enables
  output logic [36:0]      port1_oe,
  output logic [31:0]      port2_oe,
  output logic [31:0]      port3_oe,
  // function enables for the units that own the pins
  output logic             debug_port_en,
  output logic             trace_port_en,
  output logic [1:0]       bus_width,
  output logic [23:0]      address_line_en,
  output logic             clock_output_pin_en,
  output logic [3:0]       chip_select_en,
  output logic [3:0]       byte_lane_en,
  output logic             output_strobe_en,
  output logic             write_strobe_en,
  output logic [3:0]       analog_in_en
);

  // extracts a two-bit field, used for width and chip select fields
  function automatic logic [1:0] fld2(input logic [31:0] v, input int lsb);
    fld2 = v[lsb +: 2];
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mbps_pkg::mbps_state_e state_reg;
  mbps_pkg::mbps_state_e state_next;
  logic [31:0] sel_reg;
  logic [31:0] sel_next;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;

  mbps_cfg_if cfg ();

  mbps_addr_map u_addr_map (
    .cfg (cfg.decoder)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire logic hit;
  wire logic done;
  wire logic wr_en;

  // full word compare: any other address is unmapped and gets an error
  assign hit      = (paddr == mbps_pkg::SEL_ADDR);
  assign done     = psel && penable && pready_reg;
  assign wr_en    = done && pwrite && hit;

  // ---------------------------------------------------------------
  // strap capture after reset release
  // ---------------------------------------------------------------
  // straps are caught on the first edge after release, never by the
  // async reset itself; bus answers wait until then
  wire logic [31:0] strap_val;
  wire logic [31:0] strap_keep;
  wire logic [31:0] strap_bits;
  wire logic        strap_a0;
  wire logic [2:0]  strap_addr;

  assign strap_a0   = (boot_strap_pins == mbps_pkg::STRAP_BUS8);
  assign strap_addr = (boot_strap_pins == mbps_pkg::STRAP_NOBUS) ?
                      mbps_pkg::ADDR_NONE : mbps_pkg::ADDR_ALL;

  always_comb begin
    sel_next = sel_reg;
    // the strap cycle wins over a write, which cannot be answered then
    if (state_reg == mbps_pkg::ST_STRAP) begin
      sel_next = strap_val;
    end else if (wr_en) begin
      sel_next = pwdata & mbps_pkg::SEL_WR_MASK;
    end
  end

  // strapped fields replace their bits, every other bit keeps its reset value
  assign strap_bits = (32'(strap_addr) << mbps_pkg::ADDR_LSB)
                    | (32'(strap_a0) << mbps_pkg::A0_BIT)
                    | (32'(boot_strap_pins) << mbps_pkg::WIDTH_LSB);
  assign strap_keep = ~((32'(mbps_pkg::ADDR_ALL) << mbps_pkg::ADDR_LSB)
                    | (32'h0000_0001 << mbps_pkg::A0_BIT)
                    | (32'h0000_0003 << mbps_pkg::WIDTH_LSB));
  assign strap_val  = (sel_reg & strap_keep) | strap_bits;

  always_comb begin
    case (state_reg)
      mbps_pkg::ST_STRAP: state_next = mbps_pkg::ST_RUN;
      mbps_pkg::ST_RUN:   state_next = mbps_pkg::ST_RUN;
      default:            state_next = mbps_pkg::ST_STRAP;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= mbps_pkg::ST_STRAP;
      sel_reg   <= mbps_pkg::SEL_RST_VAL;
    end else begin
      state_reg <= state_next;
      sel_reg   <= sel_next;
    end
  end

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  // ready comes one cycle after setup, so every access after the strap cycle lasts one cycle;
  // a setup that fell in the strap cycle is answered one cycle later,
  // so a master that asked too early is never left waiting
  wire logic        answer;
  wire logic        pready_next;
  wire logic [31:0] prdata_next;
  wire logic        pslverr_next;

  // one answer per transfer: a standing ready blocks a second one
  assign answer       = psel && !pready_reg && (state_reg == mbps_pkg::ST_RUN);
  assign pready_next  = answer;
  assign prdata_next  = (answer && hit && !pwrite) ? sel_reg : 32'h0000_0000;
  assign pslverr_next = answer && !hit;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  wire logic [1:0] width;
  wire logic       w_low;
  wire logic       w_mid;
  wire logic       w_full;
  wire logic       dbg_sel;
  wire logic       trc_sel;
  wire logic       analog_in_four;
  wire logic       analog_in_five;
  wire logic       analog_in_six;
  wire logic       analog_in_seven;
  wire logic       cs1_sel;
  wire logic       cs2_sel;
  wire logic       cs3_sel;
  wire logic       we_sel;
  wire logic       clock_output_pin_sel;
  wire logic       a23_line;
  wire logic [21:0] amask;

  assign width  = fld2(sel_reg, mbps_pkg::WIDTH_LSB);
  assign w_low  = (width != mbps_pkg::WIDTH_NONE);
  assign w_mid  = (width == mbps_pkg::WIDTH_16) || (width == mbps_pkg::WIDTH_32);
  assign w_full = (width == mbps_pkg::WIDTH_32);

  assign dbg_sel = sel_reg[mbps_pkg::DBG_BIT];
  assign trc_sel = sel_reg[mbps_pkg::TRC_BIT];

  // analogue choices give way to the 32-bit data bus
  assign analog_in_four = !w_full && sel_reg[mbps_pkg::ANALOG_IN_FOUR_BIT];
  assign analog_in_five = !w_full && sel_reg[mbps_pkg::ANALOG_IN_FIVE_BIT];
  assign analog_in_six = !w_full && sel_reg[mbps_pkg::ANALOG_IN_SIX_BIT];
  assign analog_in_seven = !w_full && sel_reg[mbps_pkg::ANALOG_IN_SEVEN_BIT];

  // chip select codes 10 and 11 are reserved and leave the pin at port use
  assign we_sel  = sel_reg[mbps_pkg::WE_BIT];
  assign cs1_sel = sel_reg[mbps_pkg::CS1_BIT];
  assign cs2_sel = (fld2(sel_reg, mbps_pkg::CS2_LSB) == mbps_pkg::CS_SEL_CODE);
  assign cs3_sel = (fld2(sel_reg, mbps_pkg::CS3_LSB) == mbps_pkg::CS_SEL_CODE);

  assign cfg.addr_field = sel_reg[mbps_pkg::ADDR_LSB +: mbps_pkg::ADDR_W];
  assign amask          = cfg.addr_mask;

  // pin 3.23 is address line 23 when all lines are on, else port or clock
  assign a23_line = (cfg.addr_field == mbps_pkg::ADDR_ALL);
  assign clock_output_pin_sel = !a23_line && sel_reg[mbps_pkg::CLOCK_OUTPUT_PIN_BIT];

  // ---------------------------------------------------------------
  // per pin function select
  // ---------------------------------------------------------------
  logic [36:0] p1_sel;
  logic [31:0] p2_sel;
  logic [31:0] p3_sel;

  always_comb begin
    p1_sel        = 37'h0;
    p1_sel[36:26] = {11{dbg_sel}};
    p1_sel[25:16] = {10{trc_sel}};
    p1_sel[1]     = w_low;
    p1_sel[0]     = w_low;
  end

  // bit 20 has no defined function, so pins 2.29/2.28 stay port pins outside width 10
  always_comb begin
    p2_sel        = 32'h0;
    p2_sel[7:0]   = {8{w_low}};
    p2_sel[15:8]  = {8{w_mid}};
    p2_sel[27:16] = {12{w_full}};
    p2_sel[29:28] = {2{w_full}};
    p2_sel[30]    = w_full || analog_in_four;
    p2_sel[31]    = w_full || analog_in_five;
  end

  always_comb begin
    p3_sel        = 32'h0;
    p3_sel[31]    = w_low;
    p3_sel[30]    = w_mid;
    p3_sel[29]    = w_full || analog_in_six;
    p3_sel[28]    = w_full || analog_in_seven;
    p3_sel[27]    = we_sel;
    p3_sel[26]    = cs1_sel;
    p3_sel[25]    = cs2_sel;
    p3_sel[24]    = cs3_sel;
    p3_sel[23]    = amask[21] || clock_output_pin_sel;
    p3_sel[22:2]  = amask[20:0];
    p3_sel[1]     = sel_reg[mbps_pkg::A1_BIT];
    p3_sel[0]     = sel_reg[mbps_pkg::A0_BIT];
  end

  // ---------------------------------------------------------------
  // direction: port register only for general-purpose pins
  // ---------------------------------------------------------------
  wire logic [36:0] p1_oe;
  wire logic [31:0] p2_oe;
  wire logic [31:0] p3_oe;

  assign p1_oe = (p1_sel & port1_fn_oe) | (~p1_sel & port1_dir);
  assign p2_oe = (p2_sel & port2_fn_oe) | (~p2_sel & port2_dir);
  assign p3_oe = (p3_sel & port3_fn_oe) | (~p3_sel & port3_dir);

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  // all pin controls are flopped; a register write reaches the pins
  // one cycle after the bus edge that stores it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      port1_fn_sel <= 37'h0;
      port2_fn_sel <= 32'h0000_0000;
      port3_fn_sel <= 32'h0000_0000;
      port1_oe     <= 37'h0;
      port2_oe     <= 32'h0000_0000;
      port3_oe     <= 32'h0000_0000;
    end else begin
      port1_fn_sel <= p1_sel;
      port2_fn_sel <= p2_sel;
      port3_fn_sel <= p3_sel;
      port1_oe     <= p1_oe;
      port2_oe     <= p2_oe;
      port3_oe     <= p3_oe;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      debug_port_en       <= 1'b0;
      trace_port_en       <= 1'b0;
      bus_width           <= 2'h0;
      address_line_en     <= 24'h00_0000;
      clock_output_pin_en <= 1'b0;
    end else begin
      debug_port_en       <= dbg_sel;
      trace_port_en       <= trc_sel;
      bus_width           <= width;
      address_line_en     <= {amask, p3_sel[1:0]};
      clock_output_pin_en <= clock_output_pin_sel;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      chip_select_en   <= 4'h0;
      byte_lane_en     <= 4'h0;
      output_strobe_en <= 1'b0;
      write_strobe_en  <= 1'b0;
      analog_in_en     <= 4'h0;
    end else begin
      chip_select_en   <= {cs3_sel, cs2_sel, cs1_sel, w_low};
      byte_lane_en     <= {w_full, w_full, w_mid, w_low};
      output_strobe_en <= w_low;
      write_strobe_en  <= we_sel;
      analog_in_en     <= {analog_in_seven, analog_in_six, analog_in_five, analog_in_four};
    end
  end

endmodule : mbps_pin_select
`default_nettype wire

// [dv/mbps_props.sv]
// assertions on the pin select top ports
`timescale 1ns/100ps
`default_nettype none
module mbps_props (
  // clock, reset and apb
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // pins and function enables
  input wire logic [36:0] port1_dir,
  input wire logic [36:0] port1_fn_oe,
  input wire logic [36:0] port1_fn_sel,
  input wire logic [36:0] port1_oe,
  input wire logic [31:0] port2_fn_sel,
  input wire logic [31:0] port2_dir,
  input wire logic [31:0] port2_fn_oe,
  input wire logic [31:0] port2_oe,
  input wire logic [31:0] port3_dir,
  input wire logic [31:0] port3_fn_oe,
  input wire logic [31:0] port3_fn_sel,
  input wire logic [31:0] port3_oe,
  input wire logic        debug_port_en,
  input wire logic        trace_port_en,
  input wire logic [1:0]  bus_width,
  input wire logic [23:0] address_line_en,
  input wire logic        clock_output_pin_en,
  input wire logic [3:0]  chip_select_en,
  input wire logic [3:0]  byte_lane_en,
  input wire logic        output_strobe_en,
  input wire logic        write_strobe_en,
  input wire logic [3:0]  analog_in_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // pin outputs lag the strap load, so hold off for a few edges
  logic [1:0] up_reg;
  logic       live;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  assign live = (up_reg == 2'h3);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr; psel && penable && pready && pwrite && paddr == mbps_pkg::SEL_ADDR; endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_err; pready |-> (pslverr == (paddr != mbps_pkg::SEL_ADDR)); endproperty
  property p_rsv; pready |-> ((prdata & ~mbps_pkg::SEL_WR_MASK) == 32'h0000_0000); endproperty
  property p_dbg;
    s_wr |-> ##2 (debug_port_en == $past(pwdata[2], 2) && trace_port_en == $past(pwdata[3], 2)
      && port1_fn_sel[36:16] == {{11{debug_port_en}}, {10{trace_port_en}}});
  endproperty
  property p_lanes;
    live |-> (byte_lane_en == {{2{bus_width == 2'h2}}, bus_width == 2'h1 || bus_width == 2'h2,
      bus_width != 2'h3} && output_strobe_en == byte_lane_en[0] && chip_select_en[0] ==
      byte_lane_en[0] && port2_fn_sel[15:0] == {{8{byte_lane_en[1]}}, {8{byte_lane_en[0]}}});
  endproperty
  property p_ain; live && bus_width == 2'h2 |-> analog_in_en == 4'h0; endproperty
  property p_clock_output_pin; live |-> !(clock_output_pin_en && address_line_en[23]); endproperty
  property p_sel;
    s_wr |-> ##2 ({write_strobe_en, chip_select_en[3:1]} == {$past(pwdata[8], 2),
      $past(pwdata[17:16], 2) == 2'h1, $past(pwdata[15:14], 2) == 2'h1, $past(pwdata[11], 2)});
  endproperty
  property p_addr;
    s_wr |-> ##2 (address_line_en[1:0] == $past(pwdata[24:23], 2) && address_line_en[23] ==
      &$past(pwdata[27:25], 2) && address_line_en[2] == |$past(pwdata[27:25], 2));
  endproperty
  property p_oe;
    live && $stable(port1_fn_sel) |->
      port1_oe == $past(port1_fn_sel & port1_fn_oe | ~port1_fn_sel & port1_dir);
  endproperty
  property p_oe2;
    live && $stable(port2_fn_sel) |->
      port2_oe == $past(port2_fn_sel & port2_fn_oe | ~port2_fn_sel & port2_dir);
  endproperty
  property p_oe3;
    live && $stable(port3_fn_sel) |->
      port3_oe == $past(port3_fn_sel & port3_fn_oe | ~port3_fn_sel & port3_dir);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_err: assert property (p_err) else $error("error flag wrong");
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  a_dbg: assert property (p_dbg) else $error("debug or trace select wrong");
  a_lanes: assert property (p_lanes) else $error("width decode wrong");
  a_ain: assert property (p_ain) else $error("analogue on at wide bus");
  a_clock_output_pin: assert property (p_clock_output_pin) else $error("clock out with top line");
  a_sel: assert property (p_sel) else $error("strobe or select wrong");
  a_addr: assert property (p_addr) else $error("address enables wrong");
  a_oe: assert property (p_oe) else $error("pin enable source wrong");
  a_oe2: assert property (p_oe2) else $error("port 2 pin enable source wrong");
  a_oe3: assert property (p_oe3) else $error("port 3 pin enable source wrong");
endmodule // mbps_props
`default_nettype wire

// [dv/mbps_board.sv]
// far side model: owning units ask for pin drive, changing every cycle
`timescale 1ns/100ps
`default_nettype none
module mbps_board (
  // clock
  input  wire logic       clock,
  // drive wishes of the units owning the pins
  output var logic [36:0] port1_fn_oe,
  output var logic [31:0] port2_fn_oe,
  output var logic [31:0] port3_fn_oe
);
  // units steer their own direction, never the port setting
  initial begin
    {port1_fn_oe, port2_fn_oe, port3_fn_oe} = '0;
    forever begin
      @(posedge clock);
      port1_fn_oe <= {5'($urandom()), $urandom()};
      port2_fn_oe <= $urandom();
      port3_fn_oe <= ~port2_fn_oe;
    end
  end
endmodule // mbps_board
`default_nettype wire

// [dv/mbps_pin_select_tb.sv]
// self-checking bench for the memory bus pin select register
`timescale 1ns/100ps
`default_nettype none
module mbps_pin_select_tb;
  localparam int TOPS [8] = '{0, 3, 5, 7, 11, 15, 19, 23};
  localparam logic [31:0] CORNER [4] = '{32'h0E60_20E0, 32'hFFFF_FFFF, 32'h0001_4918,
                                         32'h0200_2010};
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [1:0]  boot_strap_pins, bus_width;
  logic [31:0] paddr, pwdata, prdata, q, d;
  logic [36:0] port1_dir, port1_fn_oe, port1_fn_sel, port1_oe;
  logic [31:0] port2_dir, port2_fn_oe, port2_fn_sel, port2_oe;
  logic [31:0] port3_dir, port3_fn_oe, port3_fn_sel, port3_oe;
  logic        debug_port_en, trace_port_en, clock_output_pin_en;
  logic        output_strobe_en, write_strobe_en;
  logic [23:0] address_line_en;
  logic [3:0]  chip_select_en, byte_lane_en, analog_in_en;
  logic [42:0] outs;
  logic [100:0] x;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  assign outs = {debug_port_en, trace_port_en, bus_width, address_line_en, clock_output_pin_en,
                 chip_select_en, byte_lane_en, output_strobe_en, write_strobe_en, analog_in_en};
  mbps_pin_select u_mbps_pin_select (.*);
  mbps_board u_mbps_board (.clock(clock), .port1_fn_oe(port1_fn_oe),
                           .port2_fn_oe(port2_fn_oe), .port3_fn_oe(port3_fn_oe));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [42:0] exp_out(input logic [31:0] r);
    logic [1:0]  w;
    logic [23:0] a;
    w = r[5:4];
    a = {22'h0, r[24:23]};
    for (int i = 2; i < 24; i++) a[i] = (r[27:25] != 3'h0) && (i <= TOPS[r[27:25]]);
    return {r[2], r[3], w, a, r[13] && (r[27:25] != 3'h7), r[17:16] == 2'h1, r[15:14] == 2'h1,
            r[11], w != 2'h3, {2{w == 2'h2}}, w == 2'h1 || w == 2'h2, w != 2'h3, w != 2'h3,
            r[8], (w == 2'h2) ? 4'h0 : {r[7], r[6], r[22], r[21]}};
  endfunction
  // expected function select of ports 1, 2 and 3, from the field rules
  function automatic logic [100:0] exp_sel(input logic [31:0] r);
    logic [42:0] o;
    logic        lo, mid, full;
    o = exp_out(r);
    lo = r[5:4] != 2'h3;
    mid = r[5:4] == 2'h1 || r[5:4] == 2'h2;
    full = r[5:4] == 2'h2;
    return {{11{r[2]}}, {10{r[3]}}, 14'h0, lo, lo,
            full || r[22], full || r[21], {14{full}}, {8{mid}}, {8{lo}},
            lo, mid, full || r[6], full || r[7], r[8], r[11], r[15:14] == 2'h1,
            r[17:16] == 2'h1, o[38:15] | {o[14], 23'h0}};
  endfunction
  task automatic chk(input logic [42:0] got, input logic [42:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one idle edge first, so psel never gets two values in one step
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    port1_dir <= {5'($urandom()), $urandom()};
    port2_dir <= $urandom();
    port3_dir <= $urandom();
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic do_reset(input logic [1:0] s);
    sys_rst <= 1'b1;
    boot_strap_pins <= s;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, port1_dir, port2_dir, port3_dir} = '0;
    boot_strap_pins = 2'h0;
    sys_rst = 1'b1;
    void'($urandom(29464));
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      apb(1'b0, mbps_pkg::SEL_ADDR, 32'h0);
      d = mbps_pkg::SEL_RST_VAL;
      d[5:4] = 2'(s);
      d[23] = (s == 0);
      d[27:25] = (s == 3) ? 3'h0 : 3'h7;
      chk(43'(q), 43'(d));
      chk(outs, exp_out(d));
      x = exp_sel(d);
      chk(43'(port3_fn_sel), 43'(x[31:0]));
    end
    for (int i = 0; i < 64; i++) begin
      d = (i < 4) ? CORNER[i] : $urandom();
      d = d & ~32'h0012_8000;
      apb(1'b1, mbps_pkg::SEL_ADDR, d);
      chk(43'(e), 43'h0);
      apb(1'b1, mbps_pkg::SEL_ADDR ^ (32'h4 << (i % 30)), ~d);
      chk(43'(e), 43'h1);
      apb(1'b0, mbps_pkg::SEL_ADDR, 32'h0);
      d = d & mbps_pkg::SEL_WR_MASK;
      chk(43'({e, q}), 43'({1'b0, d}));
      chk(outs, exp_out(d));
      x = exp_sel(d);
      chk(43'(port1_fn_sel), 43'(x[100:64]));
      chk(43'(port2_fn_sel), 43'(x[63:32]));
      chk(43'(port3_fn_sel), 43'(x[31:0]));
      apb(1'b0, mbps_pkg::SEL_ADDR + 32'h8, 32'h0);
      chk(43'({e, q}), 43'({1'b1, 32'h0}));
    end
    give_verdict();
  end
endmodule // mbps_pin_select_tb
bind mbps_pin_select mbps_props u_mbps_props (.*);
`default_nettype wire
